// *** src/fbo_host.sv ***
// Host controller that drives the flash bus pins for reads, writes and protection.
`timescale 1ns/10ps
`default_nettype none
`include "fbo_cfg.svh"
module fbo_host
  import fbo_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire logic [2:0] req_op_i,
  input wire logic [18:0] req_addr_i,
  input wire logic [7:0] req_wdata_i,
  input wire logic req_sig_hv_i,
  input wire logic temp_unprotect_i,
  input wire logic hold_reset_i,
  output logic rsp_valid_o,
  output logic [7:0] rsp_rdata_o,
  output logic rsp_protected_o,
  output logic [18:0] addr_o,
  output logic chip_sel_n_o,
  output logic out_en_n_o,
  output logic wr_strobe_n_o,
  output logic reset_unprotect_n_o,
  output logic addr9_high_voltage_level_o,
  output logic out_en_high_voltage_level_o,
  output logic chip_sel_high_voltage_level_o,
  output logic reset_unprotect_high_voltage_level_o,
  output logic [7:0] dq_o,
  output logic dq_oe_o,
  input wire logic [7:0] dq_i
);
  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  logic [7:0] dq_meta_q;
  logic [7:0] dq_sync_q;
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      dq_meta_q <= 8'h00;
      dq_sync_q <= 8'h00;
    end else begin
      dq_meta_q <= dq_i;
      dq_sync_q <= dq_meta_q;
    end
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  localparam logic [19:0] SETUP_CYC = 20'(`FBO_T_SETUP_CYC);
  localparam logic [19:0] PROT_CYC = 20'(`FBO_T_PROT_CYC);
  localparam logic [19:0] UNPROT_CYC = 20'(`FBO_T_UNPROT_CYC);
  // Two cycles cover the two sync stages before sampling; the setup cycle covers the output register lag.
  localparam logic [19:0] SAMPLE_CYC = 20'(`FBO_T_SETUP_CYC + 2);

  fbo_state_e state_q;
  fbo_op_e op_q;
  logic [19:0] cnt_q;
  logic [7:0] wdata_q;
  logic sig_hv_q;

  function automatic logic is_read_op(input fbo_op_e op);
    is_read_op = (op == FBO_OP_READ) || (op == FBO_OP_PROT_VERIFY) ||
                 (op == FBO_OP_UNPROT_VERIFY);
  endfunction

  // Strobe low time depends on the operation; plain writes use the setup count, reads and verifies two cycles more.
  function automatic logic [19:0] strobe_len(input fbo_op_e op);
    if (op == FBO_OP_PROTECT) begin
      strobe_len = PROT_CYC;
    end else if (op == FBO_OP_UNPROTECT) begin
      strobe_len = UNPROT_CYC;
    end else if (is_read_op(op)) begin
      strobe_len = SAMPLE_CYC;
    end else begin
      strobe_len = SETUP_CYC;
    end
  endfunction

  assign req_ready_o = (state_q == FBO_ST_IDLE) && !hold_reset_i;

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q <= FBO_ST_IDLE;
      cnt_q <= 20'h00000;
    end else begin
      case (state_q)
        FBO_ST_IDLE: begin
          if (req_valid_i && req_ready_o) begin
            state_q <= FBO_ST_SETUP;
            cnt_q <= SETUP_CYC;
          end
        end
        FBO_ST_SETUP: begin
          if (cnt_q <= 20'h00001) begin
            state_q <= FBO_ST_STROBE;
            cnt_q <= strobe_len(op_q);
          end else begin
            cnt_q <= cnt_q - 20'h00001;
          end
        end
        FBO_ST_STROBE: begin
          if (cnt_q <= 20'h00001) begin
            state_q <= is_read_op(op_q) ? FBO_ST_SAMPLE : FBO_ST_RELEASE;
            cnt_q <= SETUP_CYC;
          end else begin
            cnt_q <= cnt_q - 20'h00001;
          end
        end
        FBO_ST_SAMPLE: begin
          state_q <= FBO_ST_RELEASE;
          cnt_q <= SETUP_CYC;
        end
        FBO_ST_RELEASE: begin
          if (cnt_q <= 20'h00001) begin
            state_q <= FBO_ST_IDLE;
          end else begin
            cnt_q <= cnt_q - 20'h00001;
          end
        end
        default: begin
          state_q <= FBO_ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Request capture and address formation
  // ****************************************************************
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      op_q <= FBO_OP_READ;
      wdata_q <= 8'h00;
      sig_hv_q <= 1'b0;
      addr_o <= 19'h00000;
    end else if (state_q == FBO_ST_IDLE && req_valid_i && req_ready_o) begin
      op_q <= fbo_op_e'(req_op_i);
      wdata_q <= req_wdata_i;
      sig_hv_q <= req_sig_hv_i;
      addr_o <= req_addr_i;
      if (fbo_op_e'(req_op_i) == FBO_OP_PROT_VERIFY) begin
        addr_o[`FBO_A_ZERO] <= 1'b0;
        addr_o[`FBO_A_SIX] <= 1'b0;
        addr_o[`FBO_A_ONE] <= 1'b1;
      end else if (fbo_op_e'(req_op_i) == FBO_OP_UNPROT_VERIFY) begin
        addr_o[`FBO_A_ZERO] <= 1'b0;
        addr_o[`FBO_A_SIX] <= 1'b1;
        addr_o[`FBO_A_ONE] <= 1'b1;
      end else if (fbo_op_e'(req_op_i) == FBO_OP_UNPROTECT) begin
        addr_o[`FBO_A_TWELVE] <= 1'b1;
        addr_o[`FBO_A_FIFTEEN] <= 1'b1;
      end else if (fbo_op_e'(req_op_i) == FBO_OP_READ && req_sig_hv_i) begin
        addr_o[`FBO_A_ONE] <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Pin drive
  // ****************************************************************
  // Chip select stays high outside a cycle so the device can stand by.
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      chip_sel_n_o <= 1'b1;
      out_en_n_o <= 1'b1;
      wr_strobe_n_o <= 1'b1;
      dq_o <= 8'h00;
      dq_oe_o <= 1'b0;
    end else begin
      chip_sel_n_o <= (state_q == FBO_ST_IDLE) || (state_q == FBO_ST_RELEASE);
      out_en_n_o <= !(is_read_op(op_q) && (state_q == FBO_ST_STROBE));
      wr_strobe_n_o <= !(!is_read_op(op_q) && (state_q == FBO_ST_STROBE));
      // Data outlives the strobe by one release phase, covering the earlier rise.
      dq_o <= wdata_q;
      dq_oe_o <= (op_q == FBO_OP_WRITE) &&
                 ((state_q == FBO_ST_SETUP) || (state_q == FBO_ST_STROBE) ||
                  (state_q == FBO_ST_RELEASE));
    end
  end

  // The A9, OE and CS high-voltage qualifiers are held over the whole cycle, setup to release.
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      addr9_high_voltage_level_o <= 1'b0;
      out_en_high_voltage_level_o <= 1'b0;
      chip_sel_high_voltage_level_o <= 1'b0;
      reset_unprotect_high_voltage_level_o <= 1'b0;
      reset_unprotect_n_o <= 1'b0;
    end else begin
      addr9_high_voltage_level_o <= (state_q != FBO_ST_IDLE) &&
        ((op_q == FBO_OP_PROTECT) || (op_q == FBO_OP_UNPROTECT) ||
         (op_q == FBO_OP_PROT_VERIFY) || (op_q == FBO_OP_UNPROT_VERIFY) ||
         (op_q == FBO_OP_READ && sig_hv_q));
      out_en_high_voltage_level_o <= (state_q != FBO_ST_IDLE) &&
        ((op_q == FBO_OP_PROTECT) || (op_q == FBO_OP_UNPROTECT));
      chip_sel_high_voltage_level_o <= (state_q != FBO_ST_IDLE) &&
        (op_q == FBO_OP_UNPROTECT);
      reset_unprotect_high_voltage_level_o <= temp_unprotect_i && !hold_reset_i;
      reset_unprotect_n_o <= !hold_reset_i;
    end
  end

  // ****************************************************************
  // Response
  // ****************************************************************
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rsp_valid_o <= 1'b0;
      rsp_rdata_o <= 8'h00;
      rsp_protected_o <= 1'b0;
    end else begin
      rsp_valid_o <= (state_q == FBO_ST_SAMPLE) ||
                     ((state_q == FBO_ST_RELEASE) && (cnt_q <= 20'h00001) &&
                      !is_read_op(op_q));
      if (state_q == FBO_ST_SAMPLE) begin
        rsp_rdata_o <= dq_sync_q;
        rsp_protected_o <= (dq_sync_q == `FBO_STAT_PROT);
      end
    end
  end
endmodule
`default_nettype wire

// *** src/fbo_cfg.svh ***
// Timing counts and fixed values for the flash bus-operation host controller.
`ifndef FBO_CFG_SVH
`define FBO_CFG_SVH
`define FBO_CLK_HZ 10000000
`define FBO_T_SETUP_NS 100
`define FBO_T_SETUP_CYC ((`FBO_T_SETUP_NS * `FBO_CLK_HZ + 999999999) / 1000000000)
`define FBO_T_PROT_US 100
`define FBO_T_PROT_CYC ((`FBO_T_PROT_US * `FBO_CLK_HZ + 999999) / 1000000)
`define FBO_T_UNPROT_MS 10
`define FBO_T_UNPROT_CYC ((`FBO_T_UNPROT_MS * `FBO_CLK_HZ + 999) / 1000)
`define FBO_T_AUTOSTBY_NS 150
`define FBO_A_ZERO 0
`define FBO_A_ONE 1
`define FBO_A_SIX 6
`define FBO_A_NINE 9
`define FBO_A_TWELVE 12
`define FBO_A_FIFTEEN 15
`define FBO_BLK_LSB 13
`define FBO_STAT_PROT 8'h01
`define FBO_STAT_UNPROT 8'h00
`endif

// *** src/fbo_pkg.sv ***
// Types shared by the flash bus-operation host controller.
`default_nettype none
package fbo_pkg;
  typedef enum logic [2:0] {
    FBO_OP_READ = 3'b000,
    FBO_OP_WRITE = 3'b001,
    FBO_OP_PROTECT = 3'b010,
    FBO_OP_PROT_VERIFY = 3'b011,
    FBO_OP_UNPROTECT = 3'b100,
    FBO_OP_UNPROT_VERIFY = 3'b101
  } fbo_op_e;
  typedef enum logic [2:0] {
    FBO_ST_IDLE = 3'b000,
    FBO_ST_SETUP = 3'b001,
    FBO_ST_STROBE = 3'b010,
    FBO_ST_SAMPLE = 3'b011,
    FBO_ST_RELEASE = 3'b100
  } fbo_state_e;
endpackage
`default_nettype wire

// *** tb/fbo_host_sva.sv ***
// Pin-level assertions for the flash bus host controller.
`timescale 1ns/10ps
`default_nettype none
`include "fbo_cfg.svh"
module fbo_host_chk (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic req_ready_o,
  input wire logic hold_reset_i,
  input wire logic rsp_valid_o,
  input wire logic [18:0] addr_o,
  input wire logic chip_sel_n_o,
  input wire logic out_en_n_o,
  input wire logic wr_strobe_n_o,
  input wire logic reset_unprotect_n_o,
  input wire logic addr9_high_voltage_level_o,
  input wire logic out_en_high_voltage_level_o,
  input wire logic dq_oe_o
);
  // ***
  // Protect strobe length counter.
  // ***
  localparam int PROT_CYC = `FBO_T_PROT_CYC;
  logic [10:0] lo_q;
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lo_q <= 11'h000;
    end else begin
      // Saturates so a long unprotect strobe cannot wrap the count.
      lo_q <= wr_strobe_n_o ? 11'h000 : ((lo_q == 11'h7FF) ? lo_q : lo_q + 11'h001);
    end
  end
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_oe_win;
    !out_en_n_o [*3];
  endsequence
  chk_wr_pins: assert property (
    !wr_strobe_n_o && !out_en_high_voltage_level_o |-> out_en_n_o && !chip_sel_n_o && dq_oe_o)
    else $error("bad pins in write");
  chk_oe_cs: assert property (
    !out_en_n_o |-> !chip_sel_n_o && !dq_oe_o && wr_strobe_n_o) else $error("bad pins in read");
  chk_rd_resp: assert property (
    $fell(out_en_n_o) |-> s_oe_win ##[1:4] rsp_valid_o) else $error("read window wrong");
  chk_rsp_pulse: assert property (rsp_valid_o |=> !rsp_valid_o) else $error("rsp too long");
  chk_prot_hv: assert property (
    !wr_strobe_n_o && out_en_high_voltage_level_o |-> addr9_high_voltage_level_o)
    else $error("protect without addr hv");
  chk_prot_width: assert property (
    $rose(wr_strobe_n_o) && $past(out_en_high_voltage_level_o) |-> lo_q >= PROT_CYC)
    else $error("protect strobe short");
  chk_verify_addr: assert property (
    !out_en_n_o && addr9_high_voltage_level_o && addr_o[1] |-> !addr_o[0])
    else $error("verify addr bit zero high");
  chk_rp_follow: assert property (
    $past(rst_b_i) |-> reset_unprotect_n_o == !$past(hold_reset_i)) else $error("rp lag wrong");
  chk_ready_hold: assert property (
    hold_reset_i |-> !req_ready_o) else $error("ready in reset hold");
endmodule
bind fbo_host fbo_host_chk u_chk (.*);
`default_nettype wire

// *** tb/fbo_flash_model.sv ***
// Behavioural flash device facing the host controller.
`timescale 1ns/10ps
`default_nettype none
module fbo_flash_model #(
  parameter logic [7:0] MAKER_CODE = 8'h5A, // Arbitrary value.
  parameter logic [7:0] DEV_CODE = 8'hC3 // Arbitrary value.
) (
  input wire logic [18:0] addr_i,
  input wire logic cs_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  input wire logic rp_n_i,
  input wire logic a9_hv_i,
  input wire logic oe_hv_i,
  input wire logic cs_hv_i,
  input wire logic rp_hv_i,
  input wire logic [7:0] dq_i,
  output logic [7:0] dq_o,
  output logic dq_oe_o
);
  logic [7:0] mem [0:255];
  logic [63:0] prot = 64'h0;
  logic autosel = 1'b0;
  logic arm = 1'b0;
  logic [18:0] a_q;
  realtime t0;
  wire wact = !cs_n_i && !we_n_i && oe_n_i && !oe_hv_i;
  initial foreach (mem[i]) mem[i] = 8'hFF;
  always @(posedge wact) a_q = addr_i;
  always @(negedge wact) begin
    if (dq_i == 8'h90) autosel = 1'b1;
    else if (dq_i == 8'hF0) autosel = 1'b0;
    else if (!prot[a_q[18:13]] || rp_hv_i) mem[a_q[7:0]] = dq_i;
  end
  always @(negedge we_n_i) begin
    arm = oe_hv_i && a9_hv_i && !cs_hv_i;
    t0 = $realtime;
    if (arm) a_q = addr_i;
    if (cs_hv_i && oe_hv_i && a9_hv_i && addr_i[12] && addr_i[15]) prot <= #10ms 64'h0;
  end
  always @(posedge we_n_i) if (arm && $realtime - t0 >= 100us) prot[a_q[18:13]] = 1'b1;
  always_comb begin
    if (!(a9_hv_i || autosel)) dq_o = mem[addr_i[7:0]];
    else if (addr_i[1]) dq_o = {7'h00, prot[addr_i[18:13]]};
    else dq_o = addr_i[0] ? DEV_CODE : MAKER_CODE;
  end
  // Drives on through automatic standby; the bus never idles here.
  assign dq_oe_o = !cs_n_i && !cs_hv_i && !oe_n_i && !oe_hv_i && we_n_i && rp_n_i;
endmodule
`default_nettype wire

// *** tb/fbo_host_tb.sv ***
// Self-checking bench for the flash bus host controller.
`timescale 1ns/10ps
`default_nettype none
module fbo_host_tb;
  localparam logic [7:0] MAKER = 8'h5A; // Arbitrary value.
  localparam logic [7:0] DEVC = 8'hC3; // Arbitrary value.
  logic ref_clk_i = 0, rst_b_i = 0, req_valid_i = 0, req_sig_hv_i = 0;
  logic temp_unprotect_i = 0, hold_reset_i = 0;
  logic [2:0] req_op_i = 0;
  logic [18:0] req_addr_i = 0, addr_o;
  logic [7:0] req_wdata_i = 0, rsp_rdata_o, dq_o, m_dq, last = 0;
  logic req_ready_o, rsp_valid_o, rsp_protected_o, chip_sel_n_o, out_en_n_o, wr_strobe_n_o;
  logic reset_unprotect_n_o, dq_oe_o, m_oe, addr9_high_voltage_level_o;
  logic out_en_high_voltage_level_o, chip_sel_high_voltage_level_o;
  logic reset_unprotect_high_voltage_level_o;
  wire [7:0] hd, dq_i;
  wire hoe;
  int mismatches = 0, n_checks = 0;
  // Pad delay gives write data a hold past the strobe rise.
  assign #2 hd = dq_o;
  assign #2 hoe = dq_oe_o;
  assign dq_i = hoe ? hd : (m_oe ? m_dq : ~last);
  always @(posedge ref_clk_i) if (hoe || m_oe) last <= dq_i;
  fbo_host uut (.*);
  fbo_flash_model #(.MAKER_CODE(MAKER), .DEV_CODE(DEVC)) u_flash (.addr_i(addr_o),
    .cs_n_i(chip_sel_n_o), .oe_n_i(out_en_n_o), .we_n_i(wr_strobe_n_o),
    .rp_n_i(reset_unprotect_n_o), .a9_hv_i(addr9_high_voltage_level_o),
    .oe_hv_i(out_en_high_voltage_level_o), .cs_hv_i(chip_sel_high_voltage_level_o),
    .rp_hv_i(reset_unprotect_high_voltage_level_o), .dq_i(dq_i), .dq_o(m_dq), .dq_oe_o(m_oe));
  initial forever #50 ref_clk_i = ~ref_clk_i;
  function automatic logic [7:0] sig_exp(input logic a0);
    return a0 ? DEVC : MAKER;
  endfunction
  function automatic logic [7:0] stat_exp(input logic p);
    return p ? 8'h01 : 8'h00;
  endfunction
  task automatic end_of_test;
    if (mismatches == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic run(input logic [2:0] op, input logic [18:0] a, input logic [7:0] wd,
    input logic hv);
    int n;
    while (req_ready_o !== 1'b1) @(negedge ref_clk_i);
    {req_valid_i, req_op_i, req_addr_i, req_wdata_i, req_sig_hv_i} = {1'b1, op, a, wd, hv};
    @(negedge ref_clk_i);
    req_valid_i = 0;
    n = 0;
    while (rsp_valid_o !== 1'b1 && n < 3000) begin
      @(negedge ref_clk_i);
      n++;
    end
    if (n == 3000) begin
      mismatches++;
      end_of_test;
    end
  endtask
  task automatic rd(input logic [2:0] op, input logic [18:0] a, input logic hv,
    input logic [7:0] exp);
    run(op, a, 8'h00, hv);
    chk("rdata", rsp_rdata_o, exp);
  endtask
  initial begin
    #3ms;
    mismatches++;
    end_of_test;
  end
  initial begin
    logic [18:0] a;
    logic [7:0] d;
    void'($urandom(97));
    repeat (10) @(negedge ref_clk_i);
    rst_b_i = 1;
    for (int i = 0; i < 6; i++) begin
      a = {6'h05, 5'h00, i[3:0], 4'($urandom)};
      d = 8'($urandom) & 8'h7F;
      run(3'h1, a, d, 1'b0);
      rd(3'h0, a, 1'b0, d);
    end
    for (int b = 0; b < 2; b++) rd(3'h0, {13'($urandom), 5'h00, b[0]}, 1, sig_exp(b[0]));
    rd(3'h5, {6'h22, 13'h0000}, 1'b0, stat_exp(1'b0));
    run(3'h2, {6'h05, 13'h0000}, 8'h00, 1'b0);
    rd(3'h3, {6'h05, 13'h0000}, 1'b0, stat_exp(1'b1));
    chk("prot", {7'h00, rsp_protected_o}, 8'h01);
    run(3'h1, {6'h05, 13'h00F0}, 8'h12, 1'b0);
    rd(3'h0, {6'h05, 13'h00F0}, 1'b0, 8'hFF);
    temp_unprotect_i = 1;
    run(3'h1, {6'h05, 13'h00F0}, 8'h12, 1'b0);
    rd(3'h0, {6'h05, 13'h00F0}, 1'b0, 8'h12);
    temp_unprotect_i = 0;
    run(3'h1, {6'h05, 13'h00F0}, 8'h34, 1'b0);
    rd(3'h0, {6'h05, 13'h00F0}, 1'b0, 8'h12);
    run(3'h1, 19'h05555, 8'h90, 1'b0);
    for (int b = 0; b < 2; b++) rd(3'h0, {18'h0, b[0]}, 1'b0, sig_exp(b[0]));
    rd(3'h0, {6'h05, 13'h0002}, 1'b0, stat_exp(1'b1));
    rd(3'h0, {6'h22, 13'h0002}, 1'b0, stat_exp(1'b0));
    run(3'h1, 19'h05555, 8'hF0, 1'b0);
    hold_reset_i = 1;
    repeat (3) @(negedge ref_clk_i);
    chk("ready", {7'h00, req_ready_o}, 8'h00);
    chk("rp", {7'h00, reset_unprotect_n_o}, 8'h00);
    chk("cs", {7'h00, chip_sel_n_o}, 8'h01);
    hold_reset_i = 0;
    repeat (3) @(negedge ref_clk_i);
    chk("rp", {7'h00, reset_unprotect_n_o}, 8'h01);
    chk("ready", {7'h00, req_ready_o}, 8'h01);
    end_of_test;
  end
endmodule
`default_nettype wire
